//--- verif/ccu_chk.sv
// Port checker for the capture/compare unit.
// Assumes it is bound to the unit and sees only its ports.
`timescale 1ns/1ns
module ccu_chk
(
	input  wire        i_core_clk,
	input  wire        i_sys_rst,
	input  wire [9:0]  i_avs_address,
	input  wire        i_avs_read,
	input  wire        i_avs_write,
	input  wire [31:0] o_avs_readdata,
	input  wire        o_avs_waitrequest,
	input  wire [1:0]  o_avs_response,
	input  wire        o_capcmp_pin_oe,
	input  wire        o_capcmp_irq,
	input  wire        o_adc_start
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (i_sys_rst);
	wire       acc_done = (i_avs_read | i_avs_write) & ~o_avs_waitrequest;
	wire [7:0] acc_idx  = i_avs_address[9:2];
	wire       acc_map  = acc_idx >= 8'h15 && acc_idx <= 8'h1a;
	sequence s_answer;
		o_avs_waitrequest ##1 !o_avs_waitrequest;
	endsequence
	a_wait_one: assert property ($rose(i_avs_read | i_avs_write) |-> s_answer)
		else $error("answer not one cycle after request");
	a_reset_quiet: assert property (disable iff (1'b0) i_sys_rst |->
		!o_capcmp_irq && !o_adc_start && !o_capcmp_pin_oe)
		else $error("outputs active in reset");
	a_adc_pulse: assert property (o_adc_start |=> !o_adc_start)
		else $error("conversion start longer than one cycle");
	a_ctrl_top: assert property (acc_done && i_avs_read && acc_idx == 8'h17
		|-> o_avs_readdata[7:6] == 2'b00) else $error("control top bits set");
	a_byte_wide: assert property (acc_done && i_avs_read |->
		o_avs_readdata[31:8] == 24'h0) else $error("upper read bits set");
	a_unmapped_err: assert property (acc_done && !acc_map |->
		o_avs_response == 2'b11 && o_avs_readdata == 32'h0)
		else $error("unmapped access not refused");
	a_mapped_ok: assert property (acc_done && acc_map |-> o_avs_response == 2'b00)
		else $error("mapped access refused");
	a_flag_held: assert property ($fell(o_capcmp_irq) |->
		$past(acc_done && i_avs_write && acc_idx == 8'h18))
		else $error("interrupt dropped without software write");
endmodule
bind ccu_capture_compare_unit ccu_chk u_chk (.i_core_clk(i_core_clk),
	.i_sys_rst(i_sys_rst), .i_avs_address(i_avs_address),
	.i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
	.o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
	.o_avs_response(o_avs_response), .o_capcmp_pin_oe(o_capcmp_pin_oe),
	.o_capcmp_irq(o_capcmp_irq), .o_adc_start(o_adc_start));

//--- verif/ccu_pin_src.sv
// Pad source model: makes edges on the unit's pin input.
// Assumes the unit's drive value and enable; pad follows the unit when driven.
`timescale 1ns/1ns
module ccu_pin_src
(
	input  wire logic i_core_clk,
	input  wire logic i_oe,
	input  wire logic i_drv,
	output wire logic o_line
);
	logic lvl_q = 1'b0;
	// Driven pad loops back, so port writes can capture
	assign o_line = i_oe ? i_drv : lvl_q;
	task automatic rise(input int n);
		repeat (n)
		begin
			repeat (3) @(posedge i_core_clk);
			lvl_q <= 1'b1;
			repeat (3) @(posedge i_core_clk);
			lvl_q <= 1'b0;
		end
		// Room for the two-flop synchroniser
		repeat (4) @(posedge i_core_clk);
	endtask
endmodule

//--- verif/tb.sv
// Self-checking bench for the capture/compare unit.
// Assumes the pad source model and the bound port checker.
`timescale 1ns/1ns
module tb;
	logic        clk = 1'b0;
	logic        rst;
	logic [9:0]  addr = 10'h0;
	logic        rd_q = 1'b0;
	logic        wr_q = 1'b0;
	logic [7:0]  wdat = 8'h0;
	logic        adc_seen = 1'b0;
	int          miscompares = 0;
	int          checked = 0;
	wire  [31:0] rdata;
	wire  [1:0]  resp;
	wire         wait_rq, pin_out, pin_oe, pin_in, irq, adc;
	ccu_capture_compare_unit dut (.i_core_clk(clk), .i_sys_rst(rst),
		.i_avs_address(addr), .i_avs_read(rd_q), .i_avs_write(wr_q),
		.i_avs_writedata({24'h0, wdat}), .i_avs_byteenable(4'h1),
		.o_avs_readdata(rdata), .o_avs_waitrequest(wait_rq),
		.o_avs_response(resp), .i_capcmp_pin(pin_in), .o_capcmp_pin(pin_out),
		.o_capcmp_pin_oe(pin_oe), .o_capcmp_irq(irq), .o_adc_start(adc));
	ccu_pin_src src (.i_core_clk(clk), .i_oe(pin_oe), .i_drv(pin_out),
		.o_line(pin_in));
	initial forever #20 clk = ~clk;
	always @(posedge clk) if (adc) adc_seen <= 1'b1;
	task automatic end_sim;
		if (miscompares == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic [7:0] idx, input logic we,
		input logic [7:0] d, output logic [7:0] q);
		logic ok;
		addr <= {idx, 2'b00};
		wdat <= d;
		wr_q <= we;
		rd_q <= ~we;
		// Look just after the edge, act on the next one
		repeat (100)
		begin
			#1;
			ok = (wait_rq === 1'b0);
			q = rdata[7:0];
			@(posedge clk);
			if (ok)
				break;
		end
		wr_q <= 1'b0;
		rd_q <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		logic [7:0] q;
		bus(idx, 1'b1, d, q);
	endtask
	task automatic rdc(input logic [7:0] idx, input logic [7:0] e,
		input logic [7:0] m = 8'hff);
		logic [7:0] q;
		bus(idx, 1'b0, 8'h0, q);
		chk({24'h0, q & m}, {24'h0, e});
	endtask
	task automatic t_regs;
		rdc(8'h17, 8'h00);
		wr(8'h17, 8'hff);
		rdc(8'h17, 8'h3f);
		wr(8'h15, 8'ha5);
		wr(8'h16, 8'h5a);
		rdc(8'h15, 8'ha5);
		rdc(8'h16, 8'h5a);
		rdc(8'h30, 8'h00);
	endtask
	task automatic cap(input logic [3:0] m, input int n, input logic f);
		logic [15:0] t;
		t = {4'h9, m, n[7:0]};
		wr(8'h17, 8'h00);
		wr(8'h18, 8'h11);
		wr(8'h19, t[7:0]);
		wr(8'h1a, t[15:8]);
		wr(8'h17, {4'h0, m});
		wr(8'h18, 8'h13);
		src.rise(n);
		rdc(8'h18, {7'h0, f}, 8'h01);
		chk({31'h0, irq}, {31'h0, f});
		if (f)
		begin
			rdc(8'h15, t[7:0]);
			rdc(8'h16, t[15:8]);
		end
	endtask
	task automatic cmp(input logic [3:0] m, input logic p);
		wr(8'h17, 8'h00);
		wr(8'h18, 8'h29);
		wr(8'h19, 8'h00);
		wr(8'h1a, 8'h00);
		wr(8'h15, 8'h08);
		wr(8'h16, 8'h00);
		wr(8'h17, {4'h0, m});
		adc_seen <= 1'b0;
		wr(8'h18, 8'ha9);
		repeat (20) @(posedge clk);
		chk({31'h0, pin_out}, {31'h0, p});
		rdc(8'h18, 8'h01, 8'h05);
		chk({31'h0, adc_seen}, {31'h0, m == 4'hb});
		wr(8'h17, 8'h00);
		chk({31'h0, pin_out}, 32'h1);
		wr(8'h17, 8'h0a);
		chk({31'h0, pin_out}, 32'h0);
	endtask
	task automatic t_spev_ovf(input logic [3:0] m, input logic [7:0] e);
		wr(8'h17, 8'h00);
		wr(8'h18, 8'h15);
		wr(8'h19, 8'hfe);
		wr(8'h1a, 8'hff);
		wr(8'h15, 8'hff);
		wr(8'h16, 8'hff);
		wr(8'h17, {4'h0, m});
		wr(8'h18, 8'h95);
		repeat (4) @(posedge clk);
		rdc(8'h18, e, 8'h05);
	endtask
	initial
	begin
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_regs;
		cap(4'h5, 1, 1'b1);
		cap(4'h4, 1, 1'b1);
		cap(4'h6, 3, 1'b0);
		cap(4'h6, 3, 1'b0);
		cap(4'h6, 4, 1'b1);
		cap(4'h7, 15, 1'b0);
		cap(4'h7, 16, 1'b1);
		cmp(4'h8, 1'b1);
		cmp(4'h9, 1'b0);
		cmp(4'ha, 1'b0);
		cmp(4'hb, 1'b0);
		t_spev_ovf(4'hb, 8'h01);
		t_spev_ovf(4'ha, 8'h05);
		end_sim;
	end
	initial
	begin
		#400000;
		miscompares++;
		end_sim;
	end
endmodule

//--- verilog/ccu_capture_compare_unit.v
// Capture/compare unit with its sixteen-bit timer and an Avalon-MM slave.
// Assumes i_capcmp_pin comes from a pad (synchronised here) and that the
// conversion start pulse feeds a converter elsewhere on the same clock.
`timescale 1ns/1ns
`include "ccu_map.vh"

module ccu_capture_compare_unit
(
	input  wire                   i_core_clk,
	input  wire                   i_sys_rst,
	input  wire [`CCU_ADDR_W-1:0] i_avs_address,
	input  wire                   i_avs_read,
	input  wire                   i_avs_write,
	input  wire [31:0]            i_avs_writedata,
	input  wire [3:0]             i_avs_byteenable,
	output reg  [31:0]            o_avs_readdata,
	output wire                   o_avs_waitrequest,
	output wire [1:0]             o_avs_response,
	input  wire                   i_capcmp_pin,
	output wire                   o_capcmp_pin,
	output wire                   o_capcmp_pin_oe,
	output wire                   o_capcmp_irq,
	output reg                    o_adc_start
);

	// Bus decode
	reg        ack_q;
	reg        err_q;
	reg  [7:0] rd_mux;
	wire       req;
	wire       wr_now;
	wire [7:0] idx;
	wire       hit_lo;
	wire       hit_hi;
	wire       hit_ct;
	wire       hit_st;
	wire       hit_tl;
	wire       hit_th;
	wire       mapped;
	wire       be0;
	wire [7:0] wd;

	// Register state
	reg [7:0]  val_lo_q;
	reg [7:0]  val_hi_q;
	reg [5:0]  ctrl_q;
	reg [15:0] tmr_q;
	reg        irq_flag_q;
	reg        irq_en_q;
	reg        ovf_q;
	reg        adc_en_q;
	reg        pin_dir_q;
	reg        port_latch_q;
	reg        tmr_run_q;
	reg        cmp_latch_q;
	reg        match_seen_q;
	reg [3:0]  presc_q;
	reg        pin_s1_q;
	reg        pin_s2_q;
	reg        lvl_q;

	// Next values of the counting state
	reg [15:0] tmr_d;
	reg [3:0]  presc_d;
	reg        irq_flag_d;
	reg        ovf_d;
	reg        cmp_latch_d;
	reg        cap_event;

	// Decoded control and events
	wire [3:0]  mode;
	wire [15:0] value;
	wire        is_cap;
	wire        is_cmp;
	wire        drive_val;
	wire        lvl_now;
	wire        rise;
	wire        fall;
	wire        equal;
	wire        match;
	wire        spev;
	wire        ctrl_wr;
	wire        st_wr;
	wire        tl_wr;
	wire        th_wr;
	wire        vl_wr;
	wire        vh_wr;

	// Word index decode
	assign req    = i_avs_read | i_avs_write;
	assign wr_now = i_avs_write & ack_q;
	assign idx    = i_avs_address[`CCU_ADDR_W-1:2];
	assign hit_lo = (idx == `CCU_IDX_VALUE_LOW);
	assign hit_hi = (idx == `CCU_IDX_VALUE_HIGH);
	assign hit_ct = (idx == `CCU_IDX_CONTROL);
	assign hit_st = (idx == `CCU_IDX_STATUS);
	assign hit_tl = (idx == `CCU_IDX_TIMER_LOW);
	assign hit_th = (idx == `CCU_IDX_TIMER_HIGH);
	assign mapped = hit_lo | hit_hi | hit_ct | hit_st | hit_tl | hit_th;
	assign be0    = i_avs_byteenable[0];
	assign wd     = i_avs_writedata[7:0];

	// Writes land on the edge that ends the access, one edge after the wait state
	assign ctrl_wr = wr_now & hit_ct & be0;
	assign st_wr   = wr_now & hit_st & be0;
	assign tl_wr   = wr_now & hit_tl & be0;
	assign th_wr   = wr_now & hit_th & be0;
	assign vl_wr   = wr_now & hit_lo & be0;
	assign vh_wr   = wr_now & hit_hi & be0;

	// 11xx modes (pulse-width) decode as neither capture nor compare
	assign mode   = ctrl_q[3:0];
	assign value  = {val_hi_q, val_lo_q};
	assign is_cap = (mode[3:2] == 2'b01);
	assign is_cmp = (mode[3:2] == 2'b10);

	// Pin drives the port latch or the compare latch; the sensed
	// level follows the driven value while the pin is an output, so port writes reach capture
	assign drive_val       = is_cmp ? cmp_latch_q : port_latch_q;
	assign o_capcmp_pin    = drive_val;
	assign o_capcmp_pin_oe = ~pin_dir_q;
	assign lvl_now         = pin_dir_q ? pin_s2_q : drive_val;
	assign rise            = lvl_now & ~lvl_q;
	assign fall            = ~lvl_now & lvl_q;

	// Equality is a level; match fires once per episode of equality
	assign equal = is_cmp & (value == tmr_q);
	assign match = equal & ~match_seen_q;
	assign spev  = match & (mode == `CCU_MODE_CMP_SPEV);

	// Waitrequest is combinational so the answer needs no extra cycle
	assign o_avs_waitrequest = req & ~ack_q;
	assign o_avs_response    = err_q ? 2'b11 : 2'b00;
	assign o_capcmp_irq      = irq_flag_q & irq_en_q;

	// Capture event decode
	always @*
	begin
		cap_event = 1'b0;
		case (mode)
		`CCU_MODE_CAP_FALL:
			cap_event = fall;
		`CCU_MODE_CAP_RISE:
			cap_event = rise;
		`CCU_MODE_CAP_RISE4:
			cap_event = rise &
				({2'b00, presc_q[1:0]} == `CCU_PRESC_4_LAST);
		`CCU_MODE_CAP_RISE16:
			cap_event = rise & (presc_q == `CCU_PRESC_16_LAST);
		default:
			cap_event = 1'b0;
		endcase
	end

	// Read mux; unmapped indices read zero
	always @*
	begin
		rd_mux = 8'h00;
		case (idx)
		`CCU_IDX_VALUE_LOW:
			rd_mux = val_lo_q;
		`CCU_IDX_VALUE_HIGH:
			rd_mux = val_hi_q;
		`CCU_IDX_CONTROL:
			rd_mux = {2'b00, ctrl_q};
		`CCU_IDX_STATUS:
			rd_mux = {tmr_run_q, lvl_q, port_latch_q, pin_dir_q,
				adc_en_q, ovf_q, irq_en_q, irq_flag_q};
		`CCU_IDX_TIMER_LOW:
			rd_mux = tmr_q[7:0];
		`CCU_IDX_TIMER_HIGH:
			rd_mux = tmr_q[15:8];
		default:
			rd_mux = 8'h00;
		endcase
	end

	// One wait state per access; read data is registered
	always @(posedge i_core_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			ack_q          <= 1'b0;
			err_q          <= 1'b0;
			o_avs_readdata <= 32'h0000_0000;
		end
		else
		begin
			ack_q <= req & ~ack_q;
			err_q <= req & ~ack_q & ~mapped;
			if (i_avs_read & ~ack_q)
				o_avs_readdata <= {24'h00_0000, rd_mux};
			else
				o_avs_readdata <= 32'h0000_0000;
		end
	end

	// Two-flop pad synchroniser; only the second stage feeds logic
	// Costs two cycles of latency from a pad edge to its capture
	always @(posedge i_core_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			pin_s1_q <= 1'b0;
			pin_s2_q <= 1'b0;
			lvl_q    <= 1'b0;
		end
		else
		begin
			pin_s1_q <= i_capcmp_pin;
			pin_s2_q <= pin_s1_q;
			lvl_q    <= lvl_now;
		end
	end

	// Control: only the mode and duty bits are stored
	always @(posedge i_core_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			ctrl_q <= `CCU_CTRL_RESET;
		else if (ctrl_wr)
			ctrl_q <= wd[5:0];
	end

	// Enables, direction, port latch and timer run sit in the status word
	// Direction resets to input so the pad is not driven after reset until a status write clears bit 4
	always @(posedge i_core_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			irq_en_q     <= 1'b0;
			adc_en_q     <= 1'b0;
			pin_dir_q    <= 1'b1;
			port_latch_q <= 1'b0;
			tmr_run_q    <= 1'b0;
		end
		else if (st_wr)
		begin
			irq_en_q     <= wd[`CCU_ST_IRQ_EN];
			adc_en_q     <= wd[`CCU_ST_ADC_EN];
			pin_dir_q    <= wd[`CCU_ST_PIN_DIR];
			port_latch_q <= wd[`CCU_ST_PORT_LATCH];
			tmr_run_q    <= wd[`CCU_ST_TMR_RUN];
		end
	end

	// Flags clear by writing 1; a same-cycle event wins over the clear
	always @*
	begin
		irq_flag_d = irq_flag_q;
		if (cap_event | match)
			irq_flag_d = 1'b1;
		else if (st_wr & wd[`CCU_ST_IRQ])
			irq_flag_d = 1'b0;
	end

	// Special event clears the timer without counting as an overflow
	always @*
	begin
		ovf_d = ovf_q;
		if (tmr_run_q & ~spev & (tmr_q == 16'hffff))
			ovf_d = 1'b1;
		else if (st_wr & wd[`CCU_ST_OVF])
			ovf_d = 1'b0;
	end

	// Flag registers
	always @(posedge i_core_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			irq_flag_q <= 1'b0;
			ovf_q      <= 1'b0;
		end
		else
		begin
			irq_flag_q <= irq_flag_d;
			ovf_q      <= ovf_d;
		end
	end

	// Timer: special event beats software writes and the increment
	always @*
	begin
		tmr_d = tmr_q;
		if (spev)
			tmr_d = 16'h0000;
		else if (tl_wr)
			tmr_d = {tmr_q[15:8], wd};
		else if (th_wr)
			tmr_d = {wd, tmr_q[7:0]};
		else if (tmr_run_q)
			tmr_d = tmr_q + 16'h0001;
	end

	always @(posedge i_core_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			tmr_q <= 16'h0000;
		else
			tmr_q <= tmr_d;
	end

	// Value register; a capture wins over a software write
	always @(posedge i_core_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			val_lo_q <= 8'h00;
		else if (cap_event)
			val_lo_q <= tmr_q[7:0];
		else if (vl_wr)
			val_lo_q <= wd;
	end

	always @(posedge i_core_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			val_hi_q <= 8'h00;
		else if (cap_event)
			val_hi_q <= tmr_q[15:8];
		else if (vh_wr)
			val_hi_q <= wd;
	end

	// Prescaler: switching between capture modes keeps the count, so
	// the first capture after such a switch may come early
	always @*
	begin
		presc_d = presc_q;
		if (~is_cap)
			presc_d = 4'h0;
		else if (rise)
			presc_d = presc_q + 4'h1;
	end

	always @(posedge i_core_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			presc_q <= 4'h0;
		else
			presc_q <= presc_d;
	end

	// Compare latch: a zero control write forces it low, port latch kept
	always @*
	begin
		cmp_latch_d = cmp_latch_q;
		if (ctrl_wr & (wd[3:0] == `CCU_MODE_OFF))
			cmp_latch_d = 1'b0;
		else if (match & (mode == `CCU_MODE_CMP_SET))
			cmp_latch_d = 1'b1;
		else if (match & (mode == `CCU_MODE_CMP_CLR))
			cmp_latch_d = 1'b0;
	end

	always @(posedge i_core_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
		begin
			cmp_latch_q  <= 1'b0;
			match_seen_q <= 1'b0;
			o_adc_start  <= 1'b0;
		end
		else
		begin
			cmp_latch_q  <= cmp_latch_d;
			match_seen_q <= equal;
			o_adc_start  <= spev & adc_en_q;
		end
	end

endmodule

//--- verilog/ccu_map.vh
// Register map, field positions, reset values and mode codes of the
// capture/compare unit. Included by the unit's design file only.
//
// Contract
// - Sixteen-bit value held as two software read/write byte registers.
// - Capture copies the full timer value into the value register.
// - Mode 0100 falling, 0101 rising, 0110 fourth rising, 0111 sixteenth rising.
// - Each capture sets the interrupt request flag.
// - A new capture overwrites an unread earlier value.
// - Port latch writes on an output pin can trigger captures.
// - Mode change may set a false flag; software masks and clears.
// - Prescaler counter cleared while off or not capturing.
// - Every reset clears the prescaler counter.
// - Switching prescale settings keeps the counter; partial count possible.
// - Compare checks value against timer every cycle.
// - Match with 1000 drives pin high, 1001 low, others unchanged.
// - Match sets the flag in the same cycle as the pin action.
// - Writing zero to control forces compare output latch low.
// - Software-interrupt compare mode flags only, pin untouched.
// - Special-event match clears timer and starts conversion if enabled.
// - Special-event timer reset does not set the overflow flag.
// - Control bits 7-6 ignore writes and read zero.
`ifndef CCU_MAP_VH
`define CCU_MAP_VH

// Word indices; byte address is four times the index
`define CCU_IDX_VALUE_LOW   8'h15
`define CCU_IDX_VALUE_HIGH  8'h16
`define CCU_IDX_CONTROL     8'h17
`define CCU_IDX_STATUS      8'h18
`define CCU_IDX_TIMER_LOW   8'h19
`define CCU_IDX_TIMER_HIGH  8'h1a

`define CCU_ADDR_W          10
`define CCU_CTRL_RESET      6'h00
`define CCU_CTRL_WMASK      8'h3f

`define CCU_ST_IRQ          0
`define CCU_ST_IRQ_EN       1
`define CCU_ST_OVF          2
`define CCU_ST_ADC_EN       3
`define CCU_ST_PIN_DIR      4
`define CCU_ST_PORT_LATCH   5
`define CCU_ST_PIN_LEVEL    6
`define CCU_ST_TMR_RUN      7

`define CCU_MODE_OFF        4'h0
`define CCU_MODE_CAP_FALL   4'h4
`define CCU_MODE_CAP_RISE   4'h5
`define CCU_MODE_CAP_RISE4  4'h6
`define CCU_MODE_CAP_RISE16 4'h7
`define CCU_MODE_CMP_SET    4'h8
`define CCU_MODE_CMP_CLR    4'h9
`define CCU_MODE_CMP_SWI    4'ha
`define CCU_MODE_CMP_SPEV   4'hb

`define CCU_PRESC_4_LAST    4'h3
`define CCU_PRESC_16_LAST   4'hf

`endif
